/* File: rtl/ghi_pkg.sv */
// Package with constants and types for the bus controller host interrupt block
`default_nettype none
package ghi_pkg;
  // Interrupt status bit positions
  localparam int unsigned IS_OUT_FULL = 0;
  localparam int unsigned IS_IN_FULL = 1;
  localparam int unsigned IS_BUS_CLEAR = 3;
  localparam int unsigned IS_TALLY = 4;
  localparam int unsigned IS_SRQ = 5;
  localparam int unsigned IS_ERR = 6;
  localparam int unsigned IS_SWITCH = 7;
  // Interrupt mask bit positions
  localparam int unsigned IM_SRQ = 0;
  localparam int unsigned IM_IN_EMPTY = 2;
  localparam int unsigned IM_OUT_FULL = 3;
  localparam int unsigned IM_SWITCH = 4;
  localparam int unsigned IM_TASK = 5;
  localparam int unsigned IM_SPECIAL = 6;
  localparam int unsigned IM_FIXED = 7;
  // Error bit positions
  localparam int unsigned ER_TOUT1 = 0;
  localparam int unsigned ER_TOUT2 = 1;
  localparam int unsigned ER_TOUT3 = 2;
  localparam int unsigned ER_USER = 5;
  localparam logic [7:0] ERR_VALID = 8'h27;
  // Reset values
  localparam logic [7:0] MASK_RESET = 8'h80;
  localparam logic [7:0] ERRMASK_RESET = 8'h00;
  localparam logic [7:0] PRESET_RESET = 8'h00;
  // Command byte layout: top three bits set, then op bit and four code bits
  localparam logic [2:0] CMD_PREFIX = 3'h7;
  localparam logic [3:0] CMD_START_TALLY = 4'h0;
  localparam logic [3:0] CMD_ACK = 4'h1;
  localparam logic [3:0] CMD_READ_MASK = 4'h2;
  localparam logic [3:0] CMD_READ_ERR = 4'h3;
  localparam logic [3:0] CMD_READ_CTRL = 4'h4;
  localparam logic [3:0] CMD_READ_BUS = 4'h5;
  localparam logic [3:0] CMD_READ_COUNT = 4'h6;
  localparam logic [3:0] CMD_READ_TOUT = 4'h7;
  localparam logic [3:0] CMD_WRITE_COUNT = 4'h8;
  localparam logic [3:0] CMD_WRITE_TOUT = 4'h9;
  localparam logic [3:0] CMD_READ_ERRMASK = 4'ha;
  // Sampling: one sample per three instruction cycles
  localparam real SAMPLE_PERIOD_US = 7.5;
  localparam real CLK_MHZ = 125.0;
  localparam int unsigned SAMPLE_CYCLES = int'($ceil(SAMPLE_PERIOD_US * CLK_MHZ));
  // Bus-side inputs carried together
  typedef struct packed {
    logic srq;
    logic atn_in;
    logic ifc;
    logic sys_ctrl;
    logic eoi;
    logic dav;
    logic ren;
    logic count;
  } ghi_bus_in_t;
  // Internal events from the controller core
  typedef struct packed {
    logic task_done;
    logic tally_reached;
    logic [7:0] err_set;
    logic set_in_charge;
    logic out_load;
    logic [7:0] out_data;
    logic in_take;
  } ghi_core_ev_t;
endpackage : ghi_pkg
`default_nettype wire

/* File: rtl/ghi_sync.sv */
// Two flip-flop synchroniser, parameterised width
`default_nettype none
module ghi_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else if (en) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // ghi_sync
`default_nettype wire

/* File: rtl/ghi_host_irq.sv */
// Host status, interrupt and mask logic of the bus controller
// Notes on behaviour
// - Select line picks data/status, data/command
// - Enabled tally advances on falling edge
// - Tally input sampled every 7.5 us
// - Drive DAV in poll and sync take-control
// - Input-empty interrupt gated by its mask
// - Output-full interrupt gated by its mask
// - Drive EOI with ATN during poll
// - Special interrupt on unrequested events
// - Task-done interrupt after task and result
// - In-charge output steers SRQ transceiver
// - Special mask gates non-buffer flags except bus clear
// - Output-full clears on host data read
// - Input-full holds until device consumes byte
// - Bus clear sets flag, idles, drops charge (here charge drops only on release_charge)
// - Tally flag set at count, ack clears
// - SRQ flag set on request, ack clears
// - Error flag set with type, ack clears
// - Switch change flag, ack clears
// - Flags update even when masked, except error flag only for enabled errors
// - Mask written select low, read by command
// - Mask layout fixed one down to SRQ
// - Tally starts by command; bus clear unmasked
`default_nettype none
module ghi_host_irq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic reg_select_line,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire ghi_pkg::ghi_bus_in_t bus_in,
  input wire ghi_pkg::ghi_core_ev_t core_ev,
  input wire logic poll_active,
  input wire logic sync_take_active,
  input wire logic release_charge,
  input wire logic [7:0] timeout_count,
  output logic [7:0] in_data,
  output logic [3:0] cmd_code,
  output logic cmd_strobe,
  output logic [7:0] timeout_preset,
  output logic [7:0] error_enable_mask,
  output logic dav_out,
  output logic dav_oe_n,
  output logic eoi_out,
  output logic eoi_oe_n,
  output logic atn_out,
  output logic input_empty_irq,
  output logic output_full_irq,
  output logic special_irq,
  output logic task_done_irq,
  output logic in_charge_out
);
  ghi_pkg::ghi_bus_in_t bus_s;
  logic [2:0] strobe_s;
  logic sel_s;
  logic [7:0] din_s;
  logic rd_prev_q, wr_prev_q;
  logic rd_fall, wr_rise;
  logic [7:0] mask_q;
  logic [7:0] err_flags_q;
  logic [7:0] count_preset_q;
  logic [7:0] count_q;
  logic [7:0] status_q;
  logic [7:0] out_buf_q;
  logic [7:0] in_buf_q;
  logic [7:0] tout_preset_q;
  logic [7:0] errmask_q;
  logic tally_run_q;
  logic in_charge_q;
  logic task_done_q;
  logic sw_prev_q;
  logic cnt_prev_q;
  logic [15:0] smp_cnt_q;
  logic smp_tick;
  logic ack_cmd, mask_read_cmd, is_cmd;
  logic tally_hit;
  logic [7:0] err_hit;
  logic switch_ev;

  // Pins from outside are synchronised first
  ghi_sync #(.W(8)) u_sync_bus (
    .clk(clk),
    .rst_n(rst_n),
    .en(clk_en),
    .d(bus_in),
    .q(bus_s)
  );
  ghi_sync #(.W(12)) u_sync_host (
    .clk(clk),
    .rst_n(rst_n),
    .en(clk_en),
    .d({~cs_n, ~rd_n, ~wr_n, reg_select_line, data_in}),
    .q({strobe_s, sel_s, din_s})
  );

  // Host strobe edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else if (clk_en) begin
      rd_prev_q <= strobe_s[2] & strobe_s[1];
      wr_prev_q <= strobe_s[2] & strobe_s[0];
    end
  end
  assign rd_fall = strobe_s[2] & strobe_s[1] & ~rd_prev_q;
  assign wr_rise = wr_prev_q & ~(strobe_s[2] & strobe_s[0]);

  // Command decode: select line high on write marks a command byte
  assign is_cmd = wr_rise & sel_s & (din_s[7:5] == ghi_pkg::CMD_PREFIX);
  assign ack_cmd = is_cmd & (din_s[3:0] == ghi_pkg::CMD_ACK);
  assign mask_read_cmd = is_cmd & (din_s[3:0] == ghi_pkg::CMD_READ_MASK);

  // Interrupt mask write with select low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= ghi_pkg::MASK_RESET;
    end else if (clk_en) begin
      if (wr_rise && !sel_s && din_s[ghi_pkg::IM_FIXED]) begin
        mask_q <= din_s;
      end
    end
  end

  // Error mask write with select low and top bit clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errmask_q <= ghi_pkg::ERRMASK_RESET;
    end else if (clk_en) begin
      if (wr_rise && !sel_s && !din_s[ghi_pkg::IM_FIXED]) begin
        errmask_q <= din_s & ghi_pkg::ERR_VALID;
      end
    end
  end
  assign error_enable_mask = errmask_q;

  // Preset registers loaded by command with the data byte that follows
  logic [1:0] pend_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 2'h0;
      count_preset_q <= ghi_pkg::PRESET_RESET;
      tout_preset_q <= ghi_pkg::PRESET_RESET;
    end else if (clk_en) begin
      if (is_cmd && din_s[3:0] == ghi_pkg::CMD_WRITE_COUNT) begin
        pend_q <= 2'h1;
      end else if (is_cmd && din_s[3:0] == ghi_pkg::CMD_WRITE_TOUT) begin
        pend_q <= 2'h2;
      end else if (core_ev.in_take && pend_q == 2'h1) begin
        count_preset_q <= in_buf_q;
        pend_q <= 2'h0;
      end else if (core_ev.in_take && pend_q == 2'h2) begin
        tout_preset_q <= in_buf_q;
        pend_q <= 2'h0;
      end
    end
  end
  assign timeout_preset = tout_preset_q;

  // Input buffer: byte of any select-low write, held until the next such write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_buf_q <= 8'h00;
    end else if (clk_en && wr_rise && !sel_s) begin
      in_buf_q <= din_s;
    end
  end
  assign in_data = in_buf_q;

  // Command handoff to the core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_code <= 4'h0;
      cmd_strobe <= 1'b0;
    end else if (clk_en) begin
      cmd_strobe <= is_cmd;
      if (is_cmd) begin
        cmd_code <= din_s[3:0];
      end
    end
  end

  // Output buffer: core results and register read-backs
  logic [7:0] reply;
  always_comb begin
    reply = core_ev.out_data;
    if (is_cmd) begin
      case (din_s[3:0])
        ghi_pkg::CMD_READ_MASK: reply = mask_q;
        ghi_pkg::CMD_ACK: reply = err_flags_q;
        ghi_pkg::CMD_READ_ERR: reply = err_flags_q;
        ghi_pkg::CMD_READ_CTRL: reply = {~in_charge_q & ~status_q[ghi_pkg::IS_BUS_CLEAR],
          in_charge_q, 2'b00, bus_s.sys_ctrl, bus_s.ifc, bus_s.ren, bus_s.srq};
        ghi_pkg::CMD_READ_BUS: reply = {bus_s.ren, bus_s.dav, bus_s.eoi, 1'b0,
                                        bus_s.sys_ctrl, bus_s.ifc, bus_s.atn_in, bus_s.srq};
        ghi_pkg::CMD_READ_COUNT: reply = count_q;
        ghi_pkg::CMD_READ_TOUT: reply = timeout_count;
        ghi_pkg::CMD_READ_ERRMASK: reply = errmask_q;
        default: reply = core_ev.out_data;
      endcase
    end
  end
  logic reply_load;
  assign reply_load = core_ev.out_load | (is_cmd & (din_s[3:0] inside {ghi_pkg::CMD_ACK,
    ghi_pkg::CMD_READ_MASK, ghi_pkg::CMD_READ_ERR, ghi_pkg::CMD_READ_CTRL,
    ghi_pkg::CMD_READ_BUS, ghi_pkg::CMD_READ_COUNT, ghi_pkg::CMD_READ_TOUT,
    ghi_pkg::CMD_READ_ERRMASK}));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_buf_q <= 8'h00;
    end else if (clk_en && reply_load) begin
      out_buf_q <= reply;
    end
  end

  // Task complete: done once the mask read result is waiting, or plain finish
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      task_done_q <= 1'b0;
    end else if (clk_en) begin
      if (core_ev.task_done || mask_read_cmd) begin
        task_done_q <= 1'b1;
      end else if (is_cmd || (rd_fall && !sel_s)) begin
        task_done_q <= 1'b0;
      end
    end
  end

  // Sample tick for tally input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_cnt_q <= 16'h0000;
    end else if (clk_en) begin
      if (smp_tick) begin
        smp_cnt_q <= 16'h0000;
      end else begin
        smp_cnt_q <= smp_cnt_q + 16'h0001;
      end
    end
  end
  assign smp_tick = (smp_cnt_q == 16'(ghi_pkg::SAMPLE_CYCLES - 1));

  // Event tally counting down from preset, zero meaning 256
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_prev_q <= 1'b1;
      count_q <= 8'h00;
      tally_run_q <= 1'b0;
    end else if (clk_en) begin
      if (smp_tick) begin
        cnt_prev_q <= bus_s.count;
      end
      if (is_cmd && din_s[3:0] == ghi_pkg::CMD_START_TALLY) begin
        tally_run_q <= 1'b1;
        count_q <= count_preset_q;
      end else if (tally_run_q && smp_tick && cnt_prev_q && !bus_s.count) begin
        count_q <= count_q - 8'h01;
        if (count_q == 8'h01) begin
          tally_run_q <= 1'b0;
        end
      end
    end
  end
  assign tally_hit = (tally_run_q && smp_tick && cnt_prev_q && !bus_s.count
                     && count_q == 8'h01) | core_ev.tally_reached;

  // Switch change detect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_prev_q <= 1'b0;
    end else if (clk_en) begin
      sw_prev_q <= bus_s.sys_ctrl;
    end
  end
  assign switch_ev = sw_prev_q ^ bus_s.sys_ctrl;

  // Sticky flags, set wins over acknowledge, interrupt-masked or not; error flag only for enabled errors
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 8'h00;
    end else if (clk_en) begin
      status_q[ghi_pkg::IS_IN_FULL] <= (wr_rise & ~sel_s)
        | (status_q[ghi_pkg::IS_IN_FULL] & ~core_ev.in_take);
      status_q[ghi_pkg::IS_OUT_FULL] <= reply_load
        | (status_q[ghi_pkg::IS_OUT_FULL] & ~(rd_fall & ~sel_s));
      status_q[ghi_pkg::IS_BUS_CLEAR] <= (bus_s.ifc & ~in_charge_q)
        | (status_q[ghi_pkg::IS_BUS_CLEAR] & ~ack_cmd);
      status_q[ghi_pkg::IS_TALLY] <= tally_hit
        | (status_q[ghi_pkg::IS_TALLY] & ~ack_cmd);
      status_q[ghi_pkg::IS_SRQ] <= (bus_s.srq & in_charge_q)
        | (status_q[ghi_pkg::IS_SRQ] & ~ack_cmd);
      status_q[ghi_pkg::IS_ERR] <= (|err_hit)
        | (status_q[ghi_pkg::IS_ERR] & ~ack_cmd);
      status_q[ghi_pkg::IS_SWITCH] <= switch_ev
        | (status_q[ghi_pkg::IS_SWITCH] & ~ack_cmd);
    end
  end

  // Error type record, enabled errors only, cleared by acknowledge
  assign err_hit = core_ev.err_set & errmask_q & ghi_pkg::ERR_VALID;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_flags_q <= 8'h00;
    end else if (clk_en) begin
      err_flags_q <= err_hit | (err_flags_q & ~{8{ack_cmd}});
    end
  end

  // In-charge state, dropped on release_charge; bus clear when not in charge blocks setting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_charge_q <= 1'b0;
    end else if (clk_en) begin
      if ((bus_s.ifc && !in_charge_q) || release_charge) begin
        in_charge_q <= 1'b0;
      end else if (core_ev.set_in_charge) begin
        in_charge_q <= 1'b1;
      end
    end
  end
  assign in_charge_out = in_charge_q;

  // Bus line drive during poll and synchronous take-control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dav_out <= 1'b0;
      dav_oe_n <= 1'b1;
      eoi_out <= 1'b0;
      eoi_oe_n <= 1'b1;
      atn_out <= 1'b0;
    end else if (clk_en) begin
      dav_out <= poll_active | sync_take_active;
      dav_oe_n <= ~(poll_active | sync_take_active);
      eoi_out <= poll_active;
      eoi_oe_n <= ~poll_active;
      atn_out <= poll_active | sync_take_active;
    end
  end

  // Host data bus read: select high gives status, low gives output buffer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
    end else if (clk_en) begin
      data_out <= sel_s ? status_q : out_buf_q;
    end
  end
  assign data_oe_n = ~(strobe_s[2] & strobe_s[1]);

  // Level interrupt outputs
  assign input_empty_irq = ~status_q[ghi_pkg::IS_IN_FULL] & mask_q[ghi_pkg::IM_IN_EMPTY];
  assign output_full_irq = status_q[ghi_pkg::IS_OUT_FULL] & mask_q[ghi_pkg::IM_OUT_FULL];
  assign task_done_irq = task_done_q & mask_q[ghi_pkg::IM_TASK];
  assign special_irq = status_q[ghi_pkg::IS_BUS_CLEAR]
    | (mask_q[ghi_pkg::IM_SPECIAL] & (status_q[ghi_pkg::IS_TALLY] | status_q[ghi_pkg::IS_ERR]
    | (status_q[ghi_pkg::IS_SRQ] & mask_q[ghi_pkg::IM_SRQ])
    | (status_q[ghi_pkg::IS_SWITCH] & mask_q[ghi_pkg::IM_SWITCH])));
endmodule // ghi_host_irq
`default_nettype wire

/* File: verif/ghi_host_irq_assertions.sv */
// Port checker for the host interrupt block
`default_nettype none
module ghi_host_irq_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic reg_select_line,
  input wire logic [7:0] data_in,
  input wire logic data_oe_n,
  input wire ghi_pkg::ghi_bus_in_t bus_in,
  input wire ghi_pkg::ghi_core_ev_t core_ev,
  input wire logic poll_active,
  input wire logic sync_take_active,
  input wire logic release_charge,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_strobe,
  input wire logic dav_oe_n,
  input wire logic eoi_out,
  input wire logic eoi_oe_n,
  input wire logic atn_out,
  input wire logic input_empty_irq,
  input wire logic output_full_irq,
  input wire logic special_irq,
  input wire logic in_charge_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_poll_drive: assert property (
    $rose(poll_active) |-> ##[1:5] (!dav_oe_n && !eoi_oe_n)) else $error("poll lines idle");
  a_poll_ident: assert property (
    $rose(poll_active) |-> ##[1:5] (eoi_out && atn_out)) else $error("no identify in poll");
  a_sync_dav: assert property (
    $rose(sync_take_active) |-> ##[1:5] !dav_oe_n) else $error("dav idle in take");
  a_charge_set: assert property (
    core_ev.set_in_charge |-> ##[1:3] in_charge_out) else $error("in charge not set");
  a_charge_drop: assert property (
    release_charge |-> ##[1:3] !in_charge_out) else $error("in charge not dropped");
  a_clear_irq: assert property (
    $rose(bus_in.ifc) && !in_charge_out |-> ##[2:8] special_irq) else $error("no clear irq");
  a_data_clear: assert property (
    (!cs_n && !rd_n && !reg_select_line) [*4] ##1 rd_n |-> ##[0:6] !output_full_irq)
    else $error("out full kept after read");
  a_in_full: assert property (
    $rose(wr_n) && !cs_n && !reg_select_line && !data_in[7] |-> ##[1:6] !input_empty_irq)
    else $error("empty irq kept after write");
  a_cmd_take: assert property (
    $rose(wr_n) && !cs_n && reg_select_line && data_in[7:5] == 3'h7
    |-> ##[1:5] (cmd_strobe && cmd_code == data_in[3:0])) else $error("command not taken");
  a_read_drive: assert property (
    (!cs_n && !rd_n) [*4] |-> !data_oe_n) else $error("read data not driven");
endmodule // ghi_host_irq_assertions
bind ghi_host_irq ghi_host_irq_assertions ghi_host_irq_assertions_inst (.clk, .rst_n,
  .cs_n, .rd_n, .wr_n, .reg_select_line, .data_in, .data_oe_n, .bus_in, .core_ev,
  .poll_active, .sync_take_active, .release_charge, .cmd_code, .cmd_strobe, .dav_oe_n,
  .eoi_out, .eoi_oe_n, .atn_out, .input_empty_irq, .output_full_irq, .special_irq,
  .in_charge_out);
`default_nettype wire

/* File: verif/ghi_hm.sv */
// Host processor model on the strobe bus
`default_nettype none
module ghi_hm (
  input wire logic clk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic reg_select_line,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    reg_select_line = 1'b0;
    data_in = 8'h00;
  end
  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    reg_select_line <= sel;
    data_in <= d;
    repeat (4) @(posedge clk);
    wr_n <= 1'b1;
    repeat (6) @(posedge clk);
    cs_n <= 1'b1;
    data_in <= ~d;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd(input logic sel, output logic [7:0] q);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    reg_select_line <= sel;
    repeat (6) @(posedge clk);
    q = data_out;
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule // ghi_hm
`default_nettype wire

/* File: verif/tb_ghi_host_irq.sv */
// Testbench for the host interrupt block
`default_nettype none
module tb_ghi_host_irq;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, clk_en, cs_n, rd_n, wr_n, reg_select_line, data_oe_n, cmd_strobe;
  logic [7:0] data_in, data_out, timeout_count, in_data, timeout_preset, error_enable_mask;
  ghi_pkg::ghi_bus_in_t bus_in;
  ghi_pkg::ghi_core_ev_t core_ev;
  logic poll_active, sync_take_active, release_charge, dav_out, dav_oe_n, eoi_out, eoi_oe_n;
  logic atn_out, input_empty_irq, output_full_irq, special_irq, task_done_irq, in_charge_out;
  logic [3:0] cmd_code;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  ghi_host_irq ghi_host_irq_inst (.clk, .rst_n, .clk_en, .cs_n, .rd_n, .wr_n,
    .reg_select_line, .data_in, .data_out, .data_oe_n, .bus_in, .core_ev, .poll_active,
    .sync_take_active, .release_charge, .timeout_count, .in_data, .cmd_code, .cmd_strobe,
    .timeout_preset, .error_enable_mask, .dav_out, .dav_oe_n, .eoi_out, .eoi_oe_n, .atn_out,
    .input_empty_irq, .output_full_irq, .special_irq, .task_done_irq, .in_charge_out);
  ghi_hm ghi_hm_inst (.clk, .cs_n, .rd_n, .wr_n, .reg_select_line, .data_in, .data_out);
  always #4 clk = ~clk;
  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rs(input logic sel, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    ghi_hm_inst.rd(sel, q);
    chk(q & m, e);
  endtask
  task automatic cm(input logic [3:0] c);
    ghi_hm_inst.wr(1'b1, {ghi_pkg::CMD_PREFIX, 1'b0, c});
  endtask
  task automatic ev(input ghi_pkg::ghi_core_ev_t e);
    @(posedge clk);
    core_ev <= e;
    @(posedge clk);
    core_ev <= '0;
    w(2);
  endtask
  task automatic tk();
    bus_in.count <= 1'b1;
    w(2000);
    bus_in.count <= 1'b0;
    w(2000);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    bus_in = '0;
    core_ev = '0;
    poll_active = 1'b0;
    sync_take_active = 1'b0;
    release_charge = 1'b0;
    timeout_count = 8'h5a;
    w(3);
    rst_n <= 1'b1;
    w(2);
    chk(input_empty_irq, 8'h00);
    bus_in.ifc <= 1'b1;
    w(8);
    chk(special_irq, 8'h01);
    bus_in.ifc <= 1'b0;
    rs(1'b1, 8'h08, 8'h08);
    cm(ghi_pkg::CMD_ACK);
    rs(1'b1, 8'h08, 8'h00);
    chk(special_irq, 8'h00);
    cm(ghi_pkg::CMD_READ_MASK);
    rs(1'b1, 8'h01, 8'h01);
    rs(1'b0, 8'h7f, 8'h00);
    rs(1'b1, 8'h01, 8'h00);
    ghi_hm_inst.wr(1'b0, 8'hed);
    chk(input_empty_irq, 8'h00);
    ev(21'h000001);
    chk(input_empty_irq, 8'h01);
    cm(ghi_pkg::CMD_READ_MASK);
    chk(task_done_irq, 8'h01);
    rs(1'b0, 8'h7f, 8'h6d);
    chk(task_done_irq, 8'h00);
    ev(21'h00034a);
    chk(output_full_irq, 8'h01);
    rs(1'b0, 8'hff, 8'ha5);
    chk(output_full_irq, 8'h00);
    ghi_hm_inst.wr(1'b0, 8'h7f);
    chk(input_empty_irq, 8'h00);
    chk(error_enable_mask, 8'h27);
    chk(in_data, 8'h7f);
    rs(1'b1, 8'h02, 8'h02);
    ev(21'h000001);
    rs(1'b1, 8'h02, 8'h00);
    chk(input_empty_irq, 8'h01);
    for (int c = 0; c < 11; c++) begin
      cm(c[3:0]);
      chk({4'h0, cmd_code}, c[7:0]);
    end
    rs(1'b0, 8'hff, 8'h27);
    ghi_hm_inst.wr(1'b0, 8'h27);
    ev(21'h000001);
    chk(timeout_preset, 8'h27);
    bus_in.sys_ctrl <= 1'b1;
    w(8);
    rs(1'b1, 8'h80, 8'h80);
    chk(special_irq, 8'h00);
    ev(21'h000800);
    rs(1'b1, 8'hc0, 8'hc0);
    chk(special_irq, 8'h01);
    cm(ghi_pkg::CMD_ACK);
    rs(1'b1, 8'hc0, 8'h00);
    rs(1'b0, 8'h27, 8'h01);
    ev(21'h000400);
    chk(in_charge_out, 8'h01);
    bus_in.srq <= 1'b1;
    w(8);
    rs(1'b1, 8'h20, 8'h20);
    chk(special_irq, 8'h01);
    bus_in.srq <= 1'b0;
    cm(ghi_pkg::CMD_ACK);
    rs(1'b1, 8'h20, 8'h00);
    release_charge <= 1'b1;
    w(1);
    release_charge <= 1'b0;
    w(3);
    chk(in_charge_out, 8'h00);
    poll_active <= 1'b1;
    w(6);
    chk({dav_oe_n, eoi_oe_n, eoi_out, atn_out}, 8'h03);
    poll_active <= 1'b0;
    sync_take_active <= 1'b1;
    w(6);
    chk(dav_oe_n, 8'h00);
    chk({dav_out, dav_oe_n}, 8'h02);
    sync_take_active <= 1'b0;
    cm(ghi_pkg::CMD_WRITE_COUNT);
    ghi_hm_inst.wr(1'b0, 8'h02);
    ev(21'h000001);
    tk();
    cm(ghi_pkg::CMD_READ_COUNT);
    rs(1'b0, 8'hff, 8'hff);
    cm(ghi_pkg::CMD_START_TALLY);
    tk();
    rs(1'b1, 8'h10, 8'h00);
    tk();
    rs(1'b1, 8'h10, 8'h10);
    chk(special_irq, 8'h01);
    final_report();
  end
endmodule // tb_ghi_host_irq
`default_nettype wire
